/* File: hdl/slt_core.sv */
// Scan line switch timing, current scaling and protection shutdown logic.
`timescale 1ns/1ps
`include "slt_consts.svh"
// Notes on behaviour
// - Separate eight-bit scale codes, reset 7Fh.
// - Colour current is max times (code+1)/256.
// - Grayscale clock derived from serial clock.
// - Multiplier mode and factor pick grayscale rate.
// - Transition runs four intervals in order.
// - Transition length is the four intervals summed.
// - Length field is config word one bits 40:37.
// - Codes give 45, 60, then +30 up to 480.
// - Overtemperature turns outputs off until cooled.
// - Reference short turns outputs off until recovered.
// - Three-bit global gain code, reset 011b.
module slt_core
  import slt_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Configuration writes from the serial interface.
  input wire logic cfg_wr_i,
  input wire logic [7:0] red_scale_code_i,
  input wire logic [7:0] green_scale_code_i,
  input wire logic [7:0] blue_scale_code_i,
  input wire logic [2:0] global_gain_code_i,
  input wire logic multiplier_mode_i,
  input wire logic [3:0] multiplier_factor_i,
  input wire logic half_divider_select_i,
  input wire logic [47:0] config_word_one_i,
  // Serial clock tick and segment control.
  input wire logic sclk_tick_i,
  input wire logic pwm_done_i,
  // Analog comparator flags.
  input wire logic temp_above_hi_i,
  input wire logic temp_below_lo_i,
  input wire logic ref_below_lo_i,
  input wire logic ref_above_hi_i,
  // Current settings towards the analog sources.
  output logic [8:0] red_ratio_o,
  output logic [8:0] green_ratio_o,
  output logic [8:0] blue_ratio_o,
  output logic [2:0] global_gain_code_o,
  output logic multiplier_mode_o,
  output logic [3:0] multiplier_factor_o,
  output logic half_divider_select_o,
  output logic [3:0] line_switch_length_o,
  // Scan line sequencing outputs.
  output logic predischarge_o,
  output logic line_off_o,
  output logic next_line_on_o,
  output logic pwm_enable_o,
  output logic outputs_enable_o,
  // Protection status.
  output logic overtemp_shutdown_o,
  output logic refres_short_guard_o
);
  // Held scale codes and setting copies.
  logic [7:0] red_q;
  logic [7:0] green_q;
  logic [7:0] blue_q;
  logic [3:0] swt_q;
  // Transition sequencer state and cycle counter.
  slt_state_e state_q;
  slt_state_e state_d;
  logic [8:0] cnt_q;
  logic [8:0] cnt_d;
  logic grayscale_clock_en;
  // Decoded transition length and interval limits.
  logic [8:0] total_len;
  logic [8:0] iv3_len;
  logic [8:0] iv_limit;
  logic iv_done;
  logic prot_off;

  // Grayscale clock enable from the serial clock tick.
  slt_grayscale_clock_gen u_grayscale_clock (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .sclk_tick_i(sclk_tick_i),
    .multiplier_mode_i(multiplier_mode_o),
    .multiplier_factor_i(multiplier_factor_o),
    .half_divider_select_i(half_divider_select_o),
    .grayscale_clock_en_o(grayscale_clock_en)
  );

  // Code 0 is the odd one at 45; from code 1 each step adds 30 cycles.
  assign total_len = (swt_q == 4'h0) ? `SLT_SWT_BASE0 :
      9'(`SLT_SWT_BASE1 + 9'(swt_q - 4'h1) * `SLT_SWT_STEP);
  // Last interval absorbs the remainder so the sum is exact.
  assign iv3_len = total_len - `SLT_IV0 - `SLT_IV1 - `SLT_IV2;
  assign iv_limit = (state_q == SLT_T0) ? `SLT_IV0 :
      (state_q == SLT_T1) ? `SLT_IV1 :
      (state_q == SLT_T2) ? `SLT_IV2 : iv3_len;
  assign iv_done = grayscale_clock_en && (cnt_q == iv_limit - 9'h001);
  // Any active protection holds the outputs off.
  assign prot_off = overtemp_shutdown_o | refres_short_guard_o;

  // Configuration registers, loaded on a write strobe.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      red_q <= `SLT_SCALE_RST;
      green_q <= `SLT_SCALE_RST;
      blue_q <= `SLT_SCALE_RST;
      global_gain_code_o <= `SLT_GAIN_RST;
      multiplier_mode_o <= `SLT_MODE_RST;
      multiplier_factor_o <= `SLT_FACT_RST;
      half_divider_select_o <= `SLT_HALF_RST;
      swt_q <= `SLT_SWT_RST;
    end else if (cfg_wr_i) begin
      red_q <= red_scale_code_i;
      green_q <= green_scale_code_i;
      blue_q <= blue_scale_code_i;
      global_gain_code_o <= global_gain_code_i;
      multiplier_mode_o <= multiplier_mode_i;
      multiplier_factor_o <= multiplier_factor_i;
      // Software is trusted to match the divider to the chosen rate.
      half_divider_select_o <= half_divider_select_i;
      swt_q <= config_word_one_i[`SLT_SWT_MSB:`SLT_SWT_LSB];
    end
  end

  // Current ratio numerators over 256.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      red_ratio_o <= 9'h080;
      green_ratio_o <= 9'h080;
      blue_ratio_o <= 9'h080;
      line_switch_length_o <= `SLT_SWT_RST;
    end else begin
      red_ratio_o <= {1'b0, red_q} + 9'h001;
      green_ratio_o <= {1'b0, green_q} + 9'h001;
      blue_ratio_o <= {1'b0, blue_q} + 9'h001;
      line_switch_length_o <= swt_q;
    end
  end

  // Hysteresis latches for the two protections.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      overtemp_shutdown_o <= 1'b0;
      refres_short_guard_o <= 1'b0;
    end else begin
      if (temp_above_hi_i) begin
        overtemp_shutdown_o <= 1'b1;
      end else if (temp_below_lo_i) begin
        overtemp_shutdown_o <= 1'b0;
      end
      if (ref_below_lo_i) begin
        refres_short_guard_o <= 1'b1;
      end else if (ref_above_hi_i) begin
        refres_short_guard_o <= 1'b0;
      end
    end
  end

  // Next state: four intervals in a fixed order after each segment.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      SLT_PWM: begin
        cnt_d = 9'h000;
        if (pwm_done_i) begin
          state_d = SLT_T0;
        end
      end
      SLT_T0, SLT_T1, SLT_T2, SLT_T3: begin
        if (iv_done) begin
          cnt_d = 9'h000;
          // Each interval hands to the next; the last returns to PWM.
          case (state_q)
            SLT_T0: state_d = SLT_T1;
            SLT_T1: state_d = SLT_T2;
            SLT_T2: state_d = SLT_T3;
            default: state_d = SLT_PWM;
          endcase
        end else if (grayscale_clock_en) begin
          cnt_d = cnt_q + 9'h001;
        end
      end
      default: begin
        state_d = SLT_PWM;
        cnt_d = 9'h000;
      end
    endcase
  end

  // Sequencer registers; the block starts in a transition so PWM waits a full count.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state_q <= SLT_T0;
      cnt_q <= 9'h000;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Registered phase outputs.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      predischarge_o <= 1'b0;
      line_off_o <= 1'b0;
      next_line_on_o <= 1'b0;
      pwm_enable_o <= 1'b0;
      outputs_enable_o <= 1'b0;
    end else begin
      predischarge_o <= (state_d == SLT_T1);
      line_off_o <= (state_d == SLT_T2);
      next_line_on_o <= (state_d == SLT_T3);
      pwm_enable_o <= (state_d == SLT_PWM) && !prot_off;
      outputs_enable_o <= !prot_off;
    end
  end
endmodule

/* File: hdl/slt_consts.svh */
// Constants for the scan line switch timing block.
`ifndef SLT_CONSTS_SVH
`define SLT_CONSTS_SVH
`define SLT_SCALE_RST 8'h7f
`define SLT_GAIN_RST 3'h3
`define SLT_SWT_RST 4'h0
`define SLT_HALF_RST 1'b1
`define SLT_MODE_RST 1'b0
`define SLT_FACT_RST 4'h0
`define SLT_SWT_BASE0 9'h02d
`define SLT_SWT_BASE1 9'h03c
`define SLT_SWT_STEP 9'h01e
`define SLT_SWT_LSB 37
`define SLT_SWT_MSB 40
`define SLT_GRAYSCALE_CLOCK_MIN_MHZ 40
`define SLT_GRAYSCALE_CLOCK_MAX_MHZ 160
`define SLT_GRAYSCALE_CLOCK_HALF_MHZ 80
`define SLT_IV0 9'h008
`define SLT_IV1 9'h008
`define SLT_IV2 9'h008
`endif

/* File: hdl/slt_pkg.sv */
// Types for the scan line switch timing block.
package slt_pkg;
  typedef enum logic [2:0] {
    SLT_PWM = 3'b000,
    SLT_T0 = 3'b001,
    SLT_T1 = 3'b011,
    SLT_T2 = 3'b010,
    SLT_T3 = 3'b110
  } slt_state_e;
endpackage

/* File: hdl/slt_grayscale_clock_gen.sv */
// Grayscale clock enable generator with the optional half divider.
`timescale 1ns/1ps
module slt_grayscale_clock_gen (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Serial clock tick and multiplier settings.
  input wire logic sclk_tick_i,
  input wire logic multiplier_mode_i,
  input wire logic [3:0] multiplier_factor_i,
  input wire logic half_divider_select_i,
  // Grayscale clock enable pulse.
  output logic grayscale_clock_en_o
);
  // Multiplier stand-in: each serial tick yields factor+1 (or twice that in mode 1, but none for factor 15) pulses.
  logic [4:0] burst_q;
  logic [4:0] burst_d;
  logic half_q;
  logic raw_en;
  logic [4:0] load_val;
  assign load_val = multiplier_mode_i ? {multiplier_factor_i, 1'b1} : {1'b0, multiplier_factor_i};
  assign raw_en = (burst_q != 5'h00);
  assign burst_d = sclk_tick_i ? load_val + 5'h01 : (raw_en ? burst_q - 5'h01 : 5'h00);
  // Burst counter: a real PLL is analog, so the multiplied rate is modelled as enable pulses.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      burst_q <= 5'h00;
      half_q <= 1'b0;
      grayscale_clock_en_o <= 1'b0;
    end else begin
      burst_q <= burst_d;
      if (raw_en) begin
        half_q <= ~half_q;
      end
      // Half divider passes every second pulse when selected.
      grayscale_clock_en_o <= raw_en & (~half_divider_select_i | half_q);
    end
  end
endmodule

/* File: bench/slt_core_sva.sv */
// Port assertions for the scan line switch timing core.
`timescale 1ns/1ps
module slt_core_sva (
  // Clock, reset and inputs.
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] red_scale_code_i,
  input wire logic [2:0] global_gain_code_i,
  input wire logic [47:0] config_word_one_i,
  input wire logic temp_above_hi_i,
  input wire logic temp_below_lo_i,
  input wire logic ref_below_lo_i,
  // Watched outputs.
  input wire logic [8:0] red_ratio_o,
  input wire logic [2:0] global_gain_code_o,
  input wire logic [3:0] line_switch_length_o,
  input wire logic line_off_o,
  input wire logic predischarge_o,
  input wire logic next_line_on_o,
  input wire logic pwm_enable_o,
  input wire logic outputs_enable_o,
  input wire logic overtemp_shutdown_o,
  input wire logic refres_short_guard_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  // One configuration load.
  sequence s_wr;
    cfg_wr_i;
  endsequence
  // Ratios settle two edges after the load.
  AST_RATIO: assert property (s_wr |-> ##2
    red_ratio_o == {1'b0, $past(red_scale_code_i, 2)} + 9'h001) else $error("ratio");
  AST_GAIN: assert property (s_wr |=>
    global_gain_code_o == $past(global_gain_code_i)) else $error("gain");
  AST_LEN: assert property (s_wr |-> ##2
    line_switch_length_o == $past(config_word_one_i[40:37], 2)) else $error("length");
  AST_PRE: assert property ($rose(predischarge_o) |-> !pwm_enable_o) else $error("pre");
  AST_LOFF: assert property ($rose(line_off_o) |-> $past(predischarge_o)) else $error("off");
  AST_NON: assert property ($rose(next_line_on_o) |-> $past(line_off_o)) else $error("on");
  AST_OT: assert property (temp_above_hi_i |=> overtemp_shutdown_o) else $error("ot");
  AST_OTC: assert property (overtemp_shutdown_o && temp_below_lo_i && !temp_above_hi_i
    |=> !overtemp_shutdown_o) else $error("ot clear");
  AST_ISP: assert property (ref_below_lo_i |=> refres_short_guard_o) else $error("isp");
  AST_OFF: assert property (overtemp_shutdown_o || refres_short_guard_o
    |=> !outputs_enable_o ##0 !pwm_enable_o) else $error("enable");
endmodule
bind slt_core slt_core_sva u_sva (.*);

/* File: bench/slt_ctrl_model.sv */
// Controller model: serial clock ticks and divider choice.
`timescale 1ns/1ps
module slt_ctrl_model (
  // Requested grayscale rate in MHz.
  input wire logic [7:0] grayscale_clock_mhz_i,
  // Serial tick and divider setting.
  output logic sclk_tick_o,
  output logic half_divider_select_o
);
  // The serial clock never stops, so every cycle ticks.
  assign sclk_tick_o = 1'b1;
  // Divider on at or below 80 MHz, bypassed above.
  assign half_divider_select_o = (grayscale_clock_mhz_i <= 8'h50);
endmodule

/* File: bench/scan_line_switch_timing_tb.sv */
// Self-checking testbench for the scan line switch timing core.
`timescale 1ns/1ps
module scan_line_switch_timing_tb;
  logic clk_sys_i = 1'b0, rstn_i = 1'b0, wr_q = 1'b0, done_q = 1'b0, mode = 1'b0;
  logic t_hi = 1'b0, t_lo = 1'b0, r_lo = 1'b0, r_hi = 1'b0, tick, half;
  logic [7:0] code = 8'h00, mhz = 8'h28;
  logic [2:0] gain = 3'h4;
  logic [3:0] len = 4'h0, fact = 4'h3, fact_q, len_q;
  logic [8:0] r_rat, g_rat, b_rat;
  logic [2:0] gain_q;
  logic mode_q, half_q, pre, loff, non, pwm_en, out_en, ot, refres_short_guard;
  int failures = 0, num_checks = 0, d0, d1, d15;
  always #20 clk_sys_i = ~clk_sys_i;
  slt_ctrl_model u_ctrl (.grayscale_clock_mhz_i(mhz), .sclk_tick_o(tick), .half_divider_select_o(half));
  slt_core uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cfg_wr_i(wr_q),
    .red_scale_code_i(code), .green_scale_code_i(~code), .blue_scale_code_i(code),
    .global_gain_code_i(gain), .multiplier_mode_i(mode), .multiplier_factor_i(fact),
    .half_divider_select_i(half), .config_word_one_i({7'h00, len, 37'h0}),
    .sclk_tick_i(tick), .pwm_done_i(done_q), .temp_above_hi_i(t_hi), .temp_below_lo_i(t_lo),
    .ref_below_lo_i(r_lo), .ref_above_hi_i(r_hi), .red_ratio_o(r_rat), .green_ratio_o(g_rat),
    .blue_ratio_o(b_rat), .global_gain_code_o(gain_q), .multiplier_mode_o(mode_q),
    .multiplier_factor_o(fact_q), .half_divider_select_o(half_q), .line_switch_length_o(len_q),
    .predischarge_o(pre), .line_off_o(loff), .next_line_on_o(non), .pwm_enable_o(pwm_en),
    .outputs_enable_o(out_en), .overtemp_shutdown_o(ot), .refres_short_guard_o(refres_short_guard));
  // Counts every compare and reports a mismatch at once.
  task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One load strobe, then wait for the ratios to settle.
  task automatic wr;
    @(posedge clk_sys_i) wr_q <= 1'b1;
    @(posedge clk_sys_i) wr_q <= 1'b0;
    repeat (2) @(negedge clk_sys_i);
  endtask
  // Bounded wait for the next PWM window.
  task automatic wait_pwm(output int n);
    n = 0;
    while (pwm_en !== 1'b1) begin
      @(negedge clk_sys_i);
      n++;
      if (n > 600) begin
        failures++;
        test_done();
      end
    end
  endtask
  // Ends a segment and times the transition that follows.
  task automatic run(input logic [3:0] c, output int n);
    @(posedge clk_sys_i) len <= c;
    wr();
    chk("length", {5'h00, len_q}, {5'h00, c});
    @(posedge clk_sys_i) done_q <= 1'b1;
    @(posedge clk_sys_i) done_q <= 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk("pwm off", {8'h00, pwm_en}, 9'h000);
    wait_pwm(n);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    @(negedge clk_sys_i);
    chk("red rst", r_rat, 9'h080);
    chk("gain rst", {6'h00, gain_q}, 9'h003);
    chk("pwm rst", {8'h00, pwm_en}, 9'h000);
    wait_pwm(d0);
    wr();
    chk("half", {8'h00, half_q}, 9'h001);
    chk("factor", {5'h00, fact_q}, 9'h003);
    // Extreme and default codes; green gets the inverse code.
    // Gain 0h rides with the lowest code and 7h with the full code of 255.
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_i) begin
        code <= (i == 0) ? 8'h00 : (i == 1) ? 8'h7f : (i == 2) ? 8'hfe : 8'hff;
        gain <= (i == 0) ? 3'h0 : (i == 3) ? 3'h7 : 3'h4;
      end
      wr();
      chk("gain", {6'h00, gain_q}, {6'h00, gain});
      chk("red", r_rat, {1'b0, code} + 9'h001);
      chk("green", g_rat, {1'b0, ~code} + 9'h001);
      chk("blue", b_rat, {1'b0, code} + 9'h001);
    end
    // One grayscale pulse a cycle makes cycles equal grayscale clocks.
    @(posedge clk_sys_i) begin
      mhz <= 8'h64;
      fact <= 4'h0;
    end
    run(4'h0, d0);
    run(4'h1, d1);
    run(4'hf, d15);
    chk("mode", {8'h00, mode_q}, 9'h000);
    chk("t0", 9'((d0 >= 40) && (d0 <= 48)), 9'h001);
    chk("t1", 9'(d1 - d0), 9'h00f);
    chk("t15", 9'(d15 - d0), 9'h1b3);
    @(posedge clk_sys_i) t_hi <= 1'b1;
    repeat (3) @(negedge clk_sys_i);
    chk("ot", {8'h00, ot}, 9'h001);
    chk("oe", {8'h00, out_en}, 9'h000);
    @(posedge clk_sys_i) begin
      t_hi <= 1'b0;
      t_lo <= 1'b1;
      r_lo <= 1'b1;
    end
    repeat (3) @(negedge clk_sys_i);
    chk("ot clr", {8'h00, ot}, 9'h000);
    chk("isp", {8'h00, refres_short_guard}, 9'h001);
    chk("oe isp", {8'h00, out_en}, 9'h000);
    @(posedge clk_sys_i) begin
      r_lo <= 1'b0;
      r_hi <= 1'b1;
    end
    repeat (3) @(negedge clk_sys_i);
    chk("isp clr", {8'h00, refres_short_guard}, 9'h000);
    chk("oe on", {8'h00, out_en}, 9'h001);
    // The doubling multiplier mode must be taken as well.
    @(posedge clk_sys_i) mode <= 1'b1;
    wr();
    chk("mode 1", {8'h00, mode_q}, 9'h001);
    test_done();
  end
endmodule
